// *** hdl/eag_cfg.svh ***
`ifndef EAG_CFG_SVH
`define EAG_CFG_SVH
// register word indices; the bus byte address is index*4
`define EAG_IDX_BITREV 8'h20
`define EAG_IDX_CIRCULAR_ADDRESSING_CONTROL 8'h46
`define EAG_IDX_XSRT 8'h48
`define EAG_IDX_XEND 8'h4a
`define EAG_IDX_YSRT 8'h4c
`define EAG_IDX_YEND 8'h4e
`define EAG_IDX_DISI 8'h52
`define EAG_IDX_STAT 8'h54
// control field positions
`define EAG_XEN_BIT 15
`define EAG_YEN_BIT 14
`define EAG_BWM_HI 11
`define EAG_BWM_LO 8
`define EAG_YWM_HI 7
`define EAG_YWM_LO 4
`define EAG_XWM_HI 3
`define EAG_XWM_LO 0
`define EAG_BITREV_ENABLE_BIT 15
`define EAG_PTR_NONE 4'hf
`define EAG_CIRCULAR_ADDRESSING_CONTROL_MASK 16'hcfff
`define EAG_DISI_MASK 16'h3fff
`define EAG_RST16 16'h0000
`define EAG_NEAR_MASK 16'h1fff
`define EAG_WORD_ALIGN 16'hfffe
`define EAG_END_LSB 16'h0001
`endif

// *** hdl/eag_pkg.sv ***
package eag_pkg;
  typedef enum logic [2:0] {
    EAG_FILE_DIRECT,
    EAG_REG_DIRECT,
    EAG_INDIRECT,
    EAG_POST_MOD,
    EAG_PRE_MOD,
    EAG_REG_OFFSET,
    EAG_LIT_OFFSET,
    EAG_LITERAL
  } eag_mode_t;
  typedef enum logic [1:0] {
    EAG_CLASS_FILE,
    EAG_CLASS_MCU,
    EAG_CLASS_MOVE,
    EAG_CLASS_MAC
  } eag_class_t;
endpackage

// *** hdl/eag_top.sv ***
// Function
// (R1) Two address generators, X and Y, compute addresses independently.
// (R2) Y generator serves only word reads of multiply-accumulate class.
// (R3) Linear, circular and bit-reversed addressing are supported.
// (R4) Linear and circular addressing work for data and program space.
// (R5) Bit-reversed modification applies to data space only.
// (R6) File-register address is 13-bit field in lowest 8192 bytes.
// (R7) File-register default working register is working register zero.
// (R8) Move instruction in file-register mode reaches whole data space.
// (R9) Three-operand first operand is always a register-direct working register.
// (R10) Second operand: register, memory or 5-bit literal; result register or memory.
// (R11) Direct, indirect, post/pre-modified and 5/10-bit literal modes supported.
// (R12) File-register direct address comes only from instruction word.
// (R13) Register-direct mode uses register contents, no memory access.
// (R14) Indirect mode: address equals pointer, pointer unchanged.
// (R15) Post-modified: address is old pointer, pointer then stepped, written back.
// (R16) Pre-modified: pointer stepped first, new value is address and written back.
// (R17) Register-offset: address is pointer plus offset register.
// (R18) Literal-offset: address is pointer plus instruction literal.
// (R19) X circular needs x enable and x pointer select not 15.
// (R20) Y circular needs y enable and y pointer select not 15.
// (R21) Bit-reverse needs select not 15, enable set, pre/post increment.
// (R22) Address and write-back are produced in the same cycle.
// (R23) Unsupported mode for a class is rejected, no address issued.
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`include "eag_cfg.svh"
module eag_top
  import eag_pkg::*;
#(
  parameter int AW = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // x generator request from decoder
  input wire logic x_req_i,
  input wire eag_class_t x_class_i,
  input wire eag_mode_t x_mode_i,
  input wire logic x_prog_i,
  input wire logic [3:0] x_ptr_sel_i,
  input wire logic [AW-1:0] x_ptr_i,
  input wire logic [AW-1:0] x_off_i,
  input wire logic [AW-1:0] x_lit_i,
  input wire logic x_dec_i,
  // y generator request from decoder
  input wire logic y_req_i,
  input wire eag_class_t y_class_i,
  input wire eag_mode_t y_mode_i,
  input wire logic y_write_i,
  input wire logic y_byte_i,
  input wire logic [3:0] y_ptr_sel_i,
  input wire logic [AW-1:0] y_ptr_i,
  input wire logic [AW-1:0] y_off_i,
  input wire logic [AW-1:0] y_lit_i,
  input wire logic y_dec_i,
  // x results
  output logic x_valid_o,
  output logic x_mem_o,
  output logic [AW-1:0] x_ea_o,
  output logic x_wb_o,
  output logic [AW-1:0] x_wb_val_o,
  output logic [3:0] x_default_working_register_sel_o,
  output logic x_err_o,
  // y results
  output logic y_valid_o,
  output logic y_mem_o,
  output logic [AW-1:0] y_ea_o,
  output logic y_wb_o,
  output logic [AW-1:0] y_wb_val_o,
  output logic y_err_o
);

  logic [15:0] circular_addressing_control;
  logic [15:0] bitrev_ctl;
  logic [15:0] xsrt;
  logic [15:0] xend;
  logic [15:0] ysrt;
  logic [15:0] yend;
  logic [15:0] disi;
  logic [15:0] rd_mux;
  logic [15:0] err_cnt;
  logic [7:0] widx;
  logic wr_en;
  logic hit;

  // mode legality per instruction class
  function automatic logic mode_ok(input eag_class_t c, input eag_mode_t m);
    case (c)
      EAG_CLASS_FILE: mode_ok = (m == EAG_FILE_DIRECT);
      EAG_CLASS_MCU: mode_ok = (m == EAG_REG_DIRECT) || (m == EAG_INDIRECT) || // R9 R10 R11
        (m == EAG_POST_MOD) || (m == EAG_PRE_MOD) || (m == EAG_LITERAL);
      EAG_CLASS_MOVE: mode_ok = 1'b1;
      EAG_CLASS_MAC: mode_ok = (m == EAG_INDIRECT) || (m == EAG_POST_MOD) ||
        (m == EAG_REG_OFFSET);
      default: mode_ok = 1'b0;
    endcase
  endfunction

  // circular correction: wraps past either boundary by the buffer length
  function automatic logic [AW-1:0] wrap(input logic [AW-1:0] a, input logic [15:0] s,
    input logic [15:0] e);
    logic [AW-1:0] len;
    len = AW'(e) - AW'(s) + AW'(1);
    if (a > AW'(e))
      wrap = a - len;
    else if (a < AW'(s))
      wrap = a + len;
    else
      wrap = a;
  endfunction

  // reversed-carry add of the pivot onto a word address
  function automatic logic [AW-1:0] rev_add(input logic [AW-1:0] a, input logic [14:0] pv);
    logic [AW-1:0] ra;
    logic [AW-1:0] rp;
    logic [AW-1:0] rs;
    ra = {<<{a}};
    rp = {<<{AW'({pv, 1'b0})}};
    rs = ra + rp;
    rev_add = {<<{rs}} & AW'(`EAG_WORD_ALIGN);
  endfunction

  // register bus: zero wait, unmapped or non word-aligned addresses answer pslverr
  assign widx = paddr_i[9:2];
  assign wr_en = psel_i && penable_i && pwrite_i && hit;
  assign pready_o = 1'b1;

  always_comb
  begin
    hit = 1'b1;
    rd_mux = `EAG_RST16;
    case (widx)
      `EAG_IDX_BITREV: rd_mux = bitrev_ctl;
      `EAG_IDX_CIRCULAR_ADDRESSING_CONTROL: rd_mux = circular_addressing_control;
      `EAG_IDX_XSRT: rd_mux = xsrt;
      `EAG_IDX_XEND: rd_mux = xend;
      `EAG_IDX_YSRT: rd_mux = ysrt;
      `EAG_IDX_YEND: rd_mux = yend;
      `EAG_IDX_DISI: rd_mux = disi;
      `EAG_IDX_STAT: rd_mux = err_cnt;
      default: hit = 1'b0;
    endcase
    if (paddr_i[1:0] != 2'h0 || paddr_i[31:10] != 22'h0)
      hit = 1'b0;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      prdata_o <= 32'h0;
      pslverr_o <= 1'b0;
    end
    else
    begin
      prdata_o <= 32'h0;
      pslverr_o <= 1'b0;
      if (psel_i && !penable_i)
      begin
        prdata_o <= {16'h0, rd_mux};
        pslverr_o <= !hit;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      circular_addressing_control <= `EAG_RST16;
      bitrev_ctl <= `EAG_RST16;
      xsrt <= `EAG_RST16;
      xend <= `EAG_END_LSB;
      ysrt <= `EAG_RST16;
      yend <= `EAG_END_LSB;
      disi <= `EAG_RST16;
    end
    else if (wr_en)
    begin
      case (widx)
        `EAG_IDX_BITREV: bitrev_ctl <= pwdata_i[15:0];
        `EAG_IDX_CIRCULAR_ADDRESSING_CONTROL: circular_addressing_control <= pwdata_i[15:0] & `EAG_CIRCULAR_ADDRESSING_CONTROL_MASK;
        // start lsb fixed at 0, end lsb fixed at 1
        `EAG_IDX_XSRT: xsrt <= pwdata_i[15:0] & `EAG_WORD_ALIGN;
        `EAG_IDX_XEND: xend <= pwdata_i[15:0] | `EAG_END_LSB;
        `EAG_IDX_YSRT: ysrt <= pwdata_i[15:0] & `EAG_WORD_ALIGN;
        `EAG_IDX_YEND: yend <= pwdata_i[15:0] | `EAG_END_LSB;
        `EAG_IDX_DISI: disi <= pwdata_i[15:0] & `EAG_DISI_MASK;
        default: disi <= disi;
      endcase
    end
  end

  // separate x and y address logic, no shared core, keeps the generators independent
  logic x_ok;
  logic y_ok;
  logic x_circ;
  logic y_circ;
  logic x_brev;
  logic [AW-1:0] x_step;
  logic [AW-1:0] y_step;
  logic [AW-1:0] x_mod;
  logic [AW-1:0] y_mod;
  logic [AW-1:0] x_sum;
  logic [AW-1:0] y_sum;

  assign x_circ = circular_addressing_control[`EAG_XEN_BIT] &&
    (circular_addressing_control[`EAG_XWM_HI:`EAG_XWM_LO] != `EAG_PTR_NONE) &&
    (x_ptr_sel_i == circular_addressing_control[`EAG_XWM_HI:`EAG_XWM_LO]); // R19 R4
  assign y_circ = circular_addressing_control[`EAG_YEN_BIT] &&
    (circular_addressing_control[`EAG_YWM_HI:`EAG_YWM_LO] != `EAG_PTR_NONE) &&
    (y_ptr_sel_i == circular_addressing_control[`EAG_YWM_HI:`EAG_YWM_LO]); // R20
  assign x_brev = bitrev_ctl[`EAG_BITREV_ENABLE_BIT] && !x_prog_i && !x_dec_i && // R21 R5
    (circular_addressing_control[`EAG_BWM_HI:`EAG_BWM_LO] != `EAG_PTR_NONE) &&
    (x_ptr_sel_i == circular_addressing_control[`EAG_BWM_HI:`EAG_BWM_LO]) &&
    (x_mode_i == EAG_POST_MOD || x_mode_i == EAG_PRE_MOD);
  assign x_ok = x_req_i && mode_ok(x_class_i, x_mode_i); // R23
  assign y_ok = y_req_i && mode_ok(y_class_i, y_mode_i) && (y_class_i == EAG_CLASS_MAC) &&
    !y_write_i && !y_byte_i; // R2
  // literal step, sign from direction
  assign x_step = x_dec_i ? -x_lit_i : x_lit_i;
  assign y_step = y_dec_i ? -y_lit_i : y_lit_i;
  assign x_mod = x_brev ? rev_add(x_ptr_i, bitrev_ctl[14:0]) :
    (x_circ ? wrap(x_ptr_i + x_step, xsrt, xend) : x_ptr_i + x_step); // R3 R15 R16
  assign y_mod = y_circ ? wrap(y_ptr_i + y_step, ysrt, yend) : y_ptr_i + y_step;
  assign x_sum = x_circ ? wrap(x_ptr_i + ((x_mode_i == EAG_REG_OFFSET) ? x_off_i : x_lit_i),
    xsrt, xend) : x_ptr_i + ((x_mode_i == EAG_REG_OFFSET) ? x_off_i : x_lit_i); // R17 R18
  assign y_sum = y_circ ? wrap(y_ptr_i + y_off_i, ysrt, yend) : y_ptr_i + y_off_i;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      x_valid_o <= 1'b0;
      x_mem_o <= 1'b0;
      x_ea_o <= '0;
      x_wb_o <= 1'b0;
      x_wb_val_o <= '0;
      x_default_working_register_sel_o <= 4'h0;
      x_err_o <= 1'b0;
    end
    else
    begin
      x_valid_o <= x_ok; // R1 R22
      x_err_o <= x_req_i && !x_ok;
      x_mem_o <= x_ok && x_mode_i != EAG_REG_DIRECT && x_mode_i != EAG_LITERAL; // R13
      x_wb_o <= x_ok && (x_mode_i == EAG_POST_MOD || x_mode_i == EAG_PRE_MOD);
      x_wb_val_o <= x_mod;
      x_default_working_register_sel_o <= x_ptr_sel_i;
      x_ea_o <= '0;
      if (x_ok)
      begin
        case (x_mode_i)
          EAG_FILE_DIRECT:
          begin
            x_default_working_register_sel_o <= 4'h0; // R7
            x_ea_o <= (x_class_i == EAG_CLASS_MOVE) ? x_lit_i : // R8
              x_lit_i & AW'(`EAG_NEAR_MASK); // R6 R12
          end
          EAG_REG_DIRECT: x_ea_o <= x_ptr_i; // R13
          EAG_INDIRECT: x_ea_o <= x_ptr_i; // R14
          EAG_POST_MOD: x_ea_o <= x_ptr_i; // R15
          EAG_PRE_MOD: x_ea_o <= x_mod; // R16
          EAG_REG_OFFSET: x_ea_o <= x_sum; // R17
          EAG_LIT_OFFSET: x_ea_o <= x_sum; // R18
          EAG_LITERAL: x_ea_o <= x_lit_i; // R10 R11
          default: x_ea_o <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      y_valid_o <= 1'b0;
      y_mem_o <= 1'b0;
      y_ea_o <= '0;
      y_wb_o <= 1'b0;
      y_wb_val_o <= '0;
      y_err_o <= 1'b0;
    end
    else
    begin
      y_valid_o <= y_ok; // R1
      y_err_o <= y_req_i && !y_ok; // R23
      y_mem_o <= y_ok;
      y_wb_o <= y_ok && y_mode_i == EAG_POST_MOD;
      y_wb_val_o <= y_mod & AW'(`EAG_WORD_ALIGN);
      y_ea_o <= '0;
      if (y_ok)
      begin
        case (y_mode_i)
          EAG_REG_OFFSET: y_ea_o <= y_sum & AW'(`EAG_WORD_ALIGN);
          default: y_ea_o <= y_ptr_i & AW'(`EAG_WORD_ALIGN);
        endcase
      end
    end
  end

  // count of cycles with a rejected x or y request, read-only status
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      err_cnt <= `EAG_RST16;
    else if (x_err_o || y_err_o)
      err_cnt <= err_cnt + 16'h0001;
  end

  AST_X_ERR: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R23
    x_req_i && !mode_ok(x_class_i, x_mode_i) |=> x_err_o && !x_valid_o)
    else $error("unsupported x mode accepted");
  AST_Y_MAC: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R2
    y_valid_o |-> $past(y_class_i) == EAG_CLASS_MAC && !$past(y_write_i))
    else $error("y generator served non mac access");
  AST_Y_ERR: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R2
    y_req_i && (y_write_i || y_byte_i) |=> y_err_o && !y_valid_o)
    else $error("y generator accepted a write or byte access");
  AST_IND: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R14
    x_ok && x_mode_i == EAG_INDIRECT |=> x_ea_o == $past(x_ptr_i) && !x_wb_o)
    else $error("indirect address wrong");
  AST_POST: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R15
    x_ok && x_mode_i == EAG_POST_MOD && !x_circ && !x_brev |=>
    x_ea_o == $past(x_ptr_i) && x_wb_o && x_wb_val_o == $past(x_ptr_i) + $past(x_step))
    else $error("post modify wrong");
  AST_PRE: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R16
    x_ok && x_mode_i == EAG_PRE_MOD |=> x_ea_o == x_wb_val_o && x_wb_o)
    else $error("pre modify wrong");
  AST_PRE_LIN: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R16
    x_ok && x_mode_i == EAG_PRE_MOD && !x_circ && !x_brev |=>
    x_ea_o == $past(x_ptr_i) + $past(x_step) && x_wb_o)
    else $error("pre modify address is not the stepped pointer");
  AST_REG_OFF: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R17
    x_ok && x_mode_i == EAG_REG_OFFSET && !x_circ |=>
    x_ea_o == $past(x_ptr_i) + $past(x_off_i) && !x_wb_o)
    else $error("register offset address wrong");
  AST_LIT_OFF: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R18
    x_ok && x_mode_i == EAG_LIT_OFFSET && !x_circ |=>
    x_ea_o == $past(x_ptr_i) + $past(x_lit_i) && !x_wb_o)
    else $error("literal offset address wrong");
  AST_DIRECT: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R13
    x_ok && x_mode_i == EAG_REG_DIRECT |=> !x_mem_o)
    else $error("register direct made memory access");
  AST_NEAR: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R6
    x_ok && x_mode_i == EAG_FILE_DIRECT && x_class_i != EAG_CLASS_MOVE |=>
    x_ea_o <= AW'(`EAG_NEAR_MASK) && x_default_working_register_sel_o == 4'h0)
    else $error("file address outside near space");
  AST_XCIRC: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R19
    x_circ |-> circular_addressing_control[`EAG_XWM_HI:`EAG_XWM_LO] != `EAG_PTR_NONE)
    else $error("x circular with select 15");
  AST_XWRAP: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R3
    x_ok && x_circ && !x_brev && x_mode_i == EAG_POST_MOD && !x_dec_i &&
    x_lit_i == 16'h0002 && xend != '1 && x_ptr_i == (xend & `EAG_WORD_ALIGN) |=>
    x_wb_val_o == $past(xsrt))
    else $error("x circular buffer did not wrap to its start");
  AST_BREV: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R21
    x_brev |-> !x_prog_i && bitrev_ctl[`EAG_BITREV_ENABLE_BIT])
    else $error("bit reverse on program space");

  COV_POST: cover property (@(posedge clk_i) x_ok && x_mode_i == EAG_POST_MOD);
  COV_CIRC: cover property (@(posedge clk_i) x_ok && x_circ);
  COV_BREV: cover property (@(posedge clk_i) x_ok && x_brev);
  COV_YMAC: cover property (@(posedge clk_i) y_ok && y_mode_i == EAG_REG_OFFSET);

endmodule // eag_top

// *** testbench/eag_core_model.sv ***
`timescale 1ns/1ps
module eag_core_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // pointer read and write-back
  input wire logic [3:0] sel_i,
  output logic [15:0] ptr_o,
  input wire logic wb_i,
  input wire logic [15:0] wb_val_i
);
  logic [15:0] regs [16];
  logic [3:0] last_sel;

  assign ptr_o = regs[sel_i];

  // write-back arrives one cycle after the request, so the selection is remembered
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      last_sel <= 4'h0;
      for (int i = 0; i < 16; i++)
        regs[i] <= {i[3:0], 12'h00e};
    end
    else
    begin
      last_sel <= sel_i;
      if (wb_i)
        regs[last_sel] <= wb_val_i;
    end
  end
endmodule // eag_core_model

// *** testbench/tb.sv ***
`timescale 1ns/1ps
module tb;
  import eag_pkg::*;
  logic clk, rst_n, psel, pen, pwr, pready, pslverr, re;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic x_req, x_prog, x_dec, x_valid, x_mem, x_wb, x_err;
  logic y_req, y_wr, y_byte, y_dec, y_valid, y_mem, y_wb, y_err;
  eag_class_t x_cls, y_cls;
  eag_mode_t x_md, y_md;
  logic [3:0] x_sel, y_sel, x_wsel;
  logic [15:0] x_ptr, x_off, x_lit, x_ea, x_wbv, y_ptr, y_off, y_lit, y_ea, y_wbv;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;

  eag_top eag_top_i (
    .clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .x_req_i(x_req), .x_class_i(x_cls), .x_mode_i(x_md),
    .x_prog_i(x_prog), .x_ptr_sel_i(x_sel), .x_ptr_i(x_ptr), .x_off_i(x_off),
    .x_lit_i(x_lit), .x_dec_i(x_dec), .y_req_i(y_req), .y_class_i(y_cls),
    .y_mode_i(y_md), .y_write_i(y_wr), .y_byte_i(y_byte), .y_ptr_sel_i(y_sel),
    .y_ptr_i(y_ptr), .y_off_i(y_off), .y_lit_i(y_lit), .y_dec_i(y_dec),
    .x_valid_o(x_valid), .x_mem_o(x_mem), .x_ea_o(x_ea), .x_wb_o(x_wb),
    .x_wb_val_o(x_wbv), .x_default_working_register_sel_o(x_wsel), .x_err_o(x_err), .y_valid_o(y_valid),
    .y_mem_o(y_mem), .y_ea_o(y_ea), .y_wb_o(y_wb), .y_wb_val_o(y_wbv), .y_err_o(y_err)
  );

  eag_core_model eag_core_model_i (
    .clk_i(clk), .rst_n_i(rst_n), .sel_i(x_sel), .ptr_o(x_ptr), .wb_i(x_wb),
    .wb_val_i(x_wbv)
  );

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (fails == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    re = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp, input logic err);
    apb(1'b0, a, 32'h0);
    chk("pslverr", 32'(re), 32'(err));
    if (!err)
      chk("prdata", rd, exp);
  endtask

  // f holds decrement, write and byte flags; x pointer comes from the core model
  task automatic gen(input logic y, input eag_class_t c, input eag_mode_t m,
    input logic [3:0] s, input logic [15:0] p, input logic [15:0] o, input logic [15:0] l,
    input logic [2:0] f, input logic [15:0] ea, input logic [15:0] wbv, input logic err);
    logic mem;
    logic wbx;
    mem = !err && m != EAG_REG_DIRECT && m != EAG_LITERAL;
    wbx = !err && (m == EAG_POST_MOD || m == EAG_PRE_MOD);
    @(posedge clk);
    x_req <= !y;
    y_req <= y;
    x_cls <= c;
    y_cls <= c;
    x_md <= m;
    y_md <= m;
    x_sel <= s;
    y_sel <= s;
    y_ptr <= p;
    x_off <= o;
    y_off <= o;
    x_lit <= l;
    y_lit <= l;
    x_dec <= f[2];
    y_dec <= f[2];
    {y_wr, y_byte} <= f[1:0];
    @(posedge clk);
    x_req <= 1'b0;
    y_req <= 1'b0;
    #1;
    chk("valid", 32'(y ? y_valid : x_valid), 32'(!err));
    chk("err", 32'(y ? y_err : x_err), 32'(err));
    chk("mem", 32'(y ? y_mem : x_mem), 32'(mem));
    chk("wb", 32'(y ? y_wb : x_wb), 32'(wbx));
    if (mem)
      chk("ea", 32'(y ? y_ea : x_ea), 32'(ea));
    if (wbx)
      chk("wb_val", 32'(y ? y_wbv : x_wbv), 32'(wbv));
  endtask

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      fails = fails + 1;
      end_of_test();
    end
  end

  initial
  begin
    rst_n = 1'b0;
    {psel, pen, pwr, paddr, pwdata, x_req, x_prog, x_dec, x_sel, x_off, x_lit} = '0;
    {y_req, y_wr, y_byte, y_dec, y_sel, y_ptr, y_off, y_lit} = '0;
    x_cls = EAG_CLASS_FILE;
    y_cls = EAG_CLASS_MAC;
    x_md = EAG_INDIRECT;
    y_md = EAG_INDIRECT;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(32'h118, 32'h0, 1'b0);
    rdchk(32'h128, 32'h1, 1'b0);
    rdchk(32'h138, 32'h1, 1'b0);
    apb(1'b1, 32'h118, 32'hffff);
    rdchk(32'h118, 32'hcfff, 1'b0);
    rdchk(32'h400, 32'h0, 1'b1);
    apb(1'b1, 32'h80, 32'h8008);
    rdchk(32'h80, 32'h8008, 1'b0);
    apb(1'b1, 32'h118, 32'h0fff);
    gen(0, EAG_CLASS_FILE, EAG_FILE_DIRECT, 0, 0, 0, 16'h3ffe, 0, 16'h1ffe, 0, 0);
    chk("x_wsel", 32'(x_wsel), 32'h0);
    gen(0, EAG_CLASS_MOVE, EAG_FILE_DIRECT, 0, 0, 0, 16'h3ffe, 0, 16'h3ffe, 0, 0);
    gen(0, EAG_CLASS_MCU, EAG_REG_DIRECT, 1, 0, 0, 0, 0, 0, 0, 0);
    chk("x_wsel", 32'(x_wsel), 32'h1);
    gen(0, EAG_CLASS_MCU, EAG_INDIRECT, 1, 0, 0, 0, 0, 16'h100e, 0, 0);
    gen(0, EAG_CLASS_MCU, EAG_POST_MOD, 1, 0, 0, 2, 0, 16'h100e, 16'h1010, 0);
    gen(0, EAG_CLASS_MCU, EAG_PRE_MOD, 1, 0, 0, 4, 4, 16'h100c, 16'h100c, 0);
    gen(0, EAG_CLASS_MOVE, EAG_REG_OFFSET, 6, 0, 16'h20, 0, 0, 16'h602e, 0, 0);
    gen(0, EAG_CLASS_MOVE, EAG_LIT_OFFSET, 6, 0, 0, 16'h100, 0, 16'h610e, 0, 0);
    gen(0, EAG_CLASS_MCU, EAG_LITERAL, 0, 0, 0, 16'h1f, 0, 0, 0, 0);
    gen(0, EAG_CLASS_FILE, EAG_INDIRECT, 1, 0, 0, 0, 0, 0, 0, 1);
    gen(0, EAG_CLASS_MAC, EAG_LITERAL, 1, 0, 0, 0, 0, 0, 0, 1);
    apb(1'b1, 32'h120, 32'h2000);
    apb(1'b1, 32'h128, 32'h200f);
    apb(1'b1, 32'h118, 32'h8002);
    gen(0, EAG_CLASS_MCU, EAG_POST_MOD, 2, 0, 0, 2, 0, 16'h200e, 16'h2000, 0);
    @(posedge clk);
    x_prog <= 1'b1;
    gen(0, EAG_CLASS_MCU, EAG_PRE_MOD, 2, 0, 0, 2, 4, 16'h200e, 16'h200e, 0);
    @(posedge clk);
    x_prog <= 1'b0;
    gen(0, EAG_CLASS_MCU, EAG_POST_MOD, 3, 0, 0, 2, 0, 16'h300e, 16'h3010, 0);
    apb(1'b1, 32'h118, 32'h800f);
    gen(0, EAG_CLASS_MCU, EAG_POST_MOD, 2, 0, 0, 2, 0, 16'h200e, 16'h2010, 0);
    apb(1'b1, 32'h118, 32'h0002);
    gen(0, EAG_CLASS_MCU, EAG_PRE_MOD, 2, 0, 0, 16'h12, 4, 16'h1ffe, 16'h1ffe, 0);
    // bit reverse armed for pointer 4: program space and decrement stay linear,
    // a plain data-space increment adds the pivot with reversed carry
    apb(1'b1, 32'h118, 32'h04ff);
    @(posedge clk);
    x_prog <= 1'b1;
    gen(0, EAG_CLASS_MCU, EAG_POST_MOD, 4, 0, 0, 2, 0, 16'h400e, 16'h4010, 0);
    @(posedge clk);
    x_prog <= 1'b0;
    gen(0, EAG_CLASS_MCU, EAG_POST_MOD, 4, 0, 0, 2, 4, 16'h4010, 16'h400e, 0);
    gen(0, EAG_CLASS_MCU, EAG_POST_MOD, 4, 0, 0, 2, 0, 16'h400e, 16'h401e, 0);
    gen(1, EAG_CLASS_MAC, EAG_INDIRECT, 8, 16'h0802, 0, 0, 0, 16'h0802, 0, 0);
    gen(1, EAG_CLASS_MAC, EAG_INDIRECT, 8, 16'h0802, 0, 0, 2, 0, 0, 1);
    gen(1, EAG_CLASS_MAC, EAG_INDIRECT, 8, 16'h0802, 0, 0, 1, 0, 0, 1);
    gen(1, EAG_CLASS_MCU, EAG_INDIRECT, 8, 16'h0802, 0, 0, 0, 0, 0, 1);
    apb(1'b1, 32'h130, 32'h0800);
    apb(1'b1, 32'h138, 32'h0807);
    apb(1'b1, 32'h118, 32'h4f5f);
    gen(1, EAG_CLASS_MAC, EAG_POST_MOD, 5, 16'h0806, 0, 2, 0, 16'h0806, 16'h0800, 0);
    gen(1, EAG_CLASS_MAC, EAG_POST_MOD, 4, 16'h0806, 0, 2, 0, 16'h0806, 16'h0808, 0);
    rdchk(32'h150, 32'h5, 1'b0);
    // second reset in mid-run must bring control and status back to their reset values
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(32'h118, 32'h0, 1'b0);
    rdchk(32'h128, 32'h1, 1'b0);
    rdchk(32'h150, 32'h0, 1'b0);
    end_of_test();
  end
endmodule // tb
